// [bench/ttps_event_source.sv]
/*
  Event source model for the five counter input pins.
  Assumes the bench starts and stops it and reads the fall counts.
*/
module ttps_event_source (
  input wire logic clk_i,              // System clock
  input wire logic go_i,               // Pins toggle while set
  input wire logic [2:0] hold_i,       // Cycles per level on pin 0
  output logic [4:0] pin_o,            // Event pins, idle high
  output logic [4:0][15:0] falls_o     // Falls made on each pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int age[5] = '{default: 0};          // Cycles the level has stood
  logic [4:0] lvl = '1;                // Present pin levels, idle high
  logic [4:0][15:0] made = '0;         // Falls made so far
  assign pin_o = lvl;
  assign falls_o = made;
  // ----------------------------------------------------------------------
  // Level changes, just after the sampling edge
  // ----------------------------------------------------------------------
  always @(negedge clk_i) begin
    for (int t = 0; t < 5; t++) begin
      age[t] = age[t] + 1;
      // Pin t holds each level hold_i + t cycles, never under one
      if (go_i && age[t] >= int'(hold_i) + t) begin
        age[t] = 0;
        if (lvl[t]) made[t] = made[t] + 16'h1;
        lvl[t] = ~lvl[t];
      end
    end
  end
endmodule : ttps_event_source

// [bench/ttps_timer_tick_prescale_select_tb.sv]
/*
  Self-checking bench: register, timer ticks and pin counting.
  Assumes the event source model and the design package.
*/
module ttps_timer_tick_prescale_select_tb import ttps_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int W = 120;              // Timer window in cycles
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  ttps_ctrl_s [NUM_TIMERS-1:0] ctrl = '0;
  logic [4:0] pins, tick;
  logic [4:0][15:0] count, falls;
  logic go = 1'b0;
  logic [2:0] hold = 3'h2;
  int n_errors = 0;
  int tests_run = 0;
  int seed = 32'h26ccec69;
  logic [15:0] snap[5], fsnap[5];      // Counts at window start

  ttps_timer_tick_prescale_select i_ttps_timer_tick_prescale_select (.clk_i(clk), .sys_rst_i(sys_rst),
    .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_wdata_i(wdata), .sfr_rd_i(rd), .sfr_rdata_o(rdata),
    .timer_ctrl_i(ctrl), .event_pin_i(pins), .tick_o(tick), .count_o(count));
  ttps_event_source i_ttps_event_source (.clk_i(clk), .go_i(go), .hold_i(hold), .pin_o(pins),
    .falls_o(falls));

  always #2.5 clk = ~clk;

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  // Register access, one strobe cycle each
  task automatic sfr_access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = w;
    rd = ~w;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
    q = rdata;
  endtask : sfr_access

  task automatic take_snap();
    for (int t = 0; t < 5; t++) snap[t] = count[t];
    for (int t = 0; t < 5; t++) fsnap[t] = falls[t];
  endtask : take_snap

  // Ticks expected in one window of timer function
  function automatic logic [15:0] exp_ticks(input int t, input logic [7:0] sel, input logic baud);
    int pos[5] = '{TIMER_ZERO_TICK_BIT, TIMER_ONE_TICK_BIT, TIMER_TWO_TICK_BIT, 0, TIMER_FOUR_TICK_BIT};
    if (BAUD_CAPABLE[t] && baud) return 16'(W);
    if (HAS_TICK_SEL[t] && sel[pos[t]]) return 16'(W);
    return 16'(W / TICK_DIVIDE);
  endfunction : exp_ticks

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("watchdog expired");
    test_done();
  end

  initial begin
    logic [7:0] d, r;
    logic b;
    logic [15:0] nt[5];
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    // Reset value, stored field and address decode
    sfr_access(1'b0, TICK_DIV_SEL_ADDR, 8'h00, d);
    check("reset value", 16'(d), 16'(TICK_DIV_SEL_RESET));
    sfr_access(1'b1, TICK_DIV_SEL_ADDR, 8'hff, d);
    sfr_access(1'b1, 8'h8f, 8'h00, d);
    sfr_access(1'b0, TICK_DIV_SEL_ADDR, 8'h00, d);
    check("select field", 16'(d), 16'h0078);
    sfr_access(1'b0, 8'h8f, 8'h00, d);
    check("unmapped read", 16'(d), 16'h0000);
    $display("test register done");
    // Timer function: corner selects, then random selects and baud mode
    for (int i = 0; i < 6; i++) begin
      r = (i == 0) ? 8'h00 : (i == 1) ? 8'h78 : 8'($random(seed));
      b = (i > 1) ? 1'($random(seed)) : 1'b0;
      sfr_access(1'b1, TICK_DIV_SEL_ADDR, r, d);
      for (int t = 0; t < 5; t++) ctrl[t] = '{1'b1, 1'b0, b};
      repeat (30) @(negedge clk);
      take_snap();
      nt = '{default: 0};
      for (int c = 0; c < W; c++) begin
        @(negedge clk);
        for (int t = 0; t < 5; t++) nt[t] += 16'(tick[t]);
      end
      for (int t = 0; t < 5; t++) check("timer count", count[t] - snap[t], exp_ticks(t, r, b));
      for (int t = 0; t < 5; t++) check("tick pulses", nt[t], exp_ticks(t, r, b));
      $display("test timer %0d done", i);
    end
    // Counter function: fastest pins first, one timer stopped each pass
    for (int i = 0; i < 5; i++) begin
      r = 8'($random(seed));
      hold = (i == 0) ? 3'h2 : 3'(2 + {$random(seed)} % 4);
      sfr_access(1'b1, TICK_DIV_SEL_ADDR, r, d);
      for (int t = 0; t < 5; t++) ctrl[t] = '{t != 4 - i, 1'b1, 1'($random(seed))};
      repeat (8) @(negedge clk);
      take_snap();
      go = 1'b1;
      repeat (150) @(negedge clk);
      go = 1'b0;
      repeat (8) @(negedge clk);
      for (int t = 0; t < 5; t++) check("event count", count[t] - snap[t], (t != 4 - i) ? falls[t] - fsnap[t] : 16'h0);
      $display("test counter %0d done", i);
    end
    // Reset in mid-run clears counts, ticks and the select field
    sfr_access(1'b1, TICK_DIV_SEL_ADDR, 8'hff, d);
    @(negedge clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    for (int t = 0; t < 5; t++) check("reset count", count[t], 16'h0000);
    check("reset ticks", 16'(tick), 16'h0000);
    sys_rst = 1'b0;
    sfr_access(1'b0, TICK_DIV_SEL_ADDR, 8'h00, d);
    check("reset select", 16'(d), 16'(TICK_DIV_SEL_RESET));
    $display("test reset done");
    test_done();
  end
endmodule : ttps_timer_tick_prescale_select_tb

// [rtl/ttps_pkg.sv]
/*
  Constants and carrier types for the timer tick front end: the clock-control
  register, the divide-by-twelve prescaler and the per-timer control bundle.
  Assumes a single system clock and an SFR-style byte register port.
*/
package ttps_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_TIMERS = 5;        // Counter/timers served
  localparam int unsigned COUNT_W = 16;          // Count register width
  localparam int unsigned SFR_AW = 8;            // Register address width
  localparam int unsigned SFR_DW = 8;            // Register data width

  // ----------------------------------------------------------------------
  // Clock-control register
  // ----------------------------------------------------------------------
  localparam logic [SFR_AW-1:0] TICK_DIV_SEL_ADDR = 8'h8e;   // Register offset
  localparam logic [SFR_DW-1:0] TICK_DIV_SEL_RESET = 8'h00;  // Reset value
  localparam int unsigned TIMER_ZERO_TICK_BIT = 3;           // Timer 0 select
  localparam int unsigned TIMER_ONE_TICK_BIT = 4;            // Timer 1 select
  localparam int unsigned TIMER_TWO_TICK_BIT = 5;            // Timer 2 select
  localparam int unsigned TIMER_FOUR_TICK_BIT = 6;           // Timer 4 select
  localparam int unsigned TICK_FIELD_LSB = 3;                // Lowest select bit
  localparam int unsigned TICK_FIELD_MSB = 6;                // Highest select bit

  // ----------------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------------
  localparam int unsigned TICK_DIVIDE = 12;                  // Legacy divide
  localparam logic [3:0] PRESCALE_LAST = 4'(TICK_DIVIDE - 1);
  localparam logic [3:0] PRESCALE_ZERO = 4'h0;

  // Timers that carry a baud generator mode
  localparam logic [NUM_TIMERS-1:0] BAUD_CAPABLE = 5'h14;    // Timers 2 and 4
  // Timers that own a select bit; in timer function the rest always take the slow tick
  localparam logic [NUM_TIMERS-1:0] HAS_TICK_SEL = 5'h17;    // Timers 0,1,2,4

  // ----------------------------------------------------------------------
  // Per-timer control bundle
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic run;             // Count register advances when set
    logic count_source;    // Set: count falling edges of the pin
    logic baud_mode;       // Set: baud-rate generator mode
  } ttps_ctrl_s;

endpackage : ttps_pkg

// [rtl/ttps_timer_tick_prescale_select.sv]
/*
  Tick front end for five counter/timers: the clock-control register, the
  divide-by-twelve prescaler, pin edge detectors, per-timer tick selection
  and each timer's 16-bit count register.
  Assumes event pins are asynchronous to clk_i; control bundles come from
  logic on clk_i; register accesses are single-cycle strobes.
*/
module ttps_timer_tick_prescale_select
  import ttps_pkg::*;
(
  input wire logic clk_i,                                   // System clock
  input wire logic sys_rst_i,                               // Sync reset, high
  input wire logic [SFR_AW-1:0] sfr_addr_i,                 // Register address
  input wire logic sfr_wr_i,                                // Write strobe
  input wire logic [SFR_DW-1:0] sfr_wdata_i,                // Write data
  input wire logic sfr_rd_i,                                // Read strobe
  output logic [SFR_DW-1:0] sfr_rdata_o,                    // Read data
  input wire ttps_ctrl_s [NUM_TIMERS-1:0] timer_ctrl_i,     // Per-timer control
  input wire logic [NUM_TIMERS-1:0] event_pin_i,            // External inputs
  output logic [NUM_TIMERS-1:0] tick_o,                     // Tick pulses
  output logic [NUM_TIMERS-1:0][COUNT_W-1:0] count_o        // Count registers
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [TICK_FIELD_MSB:TICK_FIELD_LSB] tick_sel;    // Stored select bits
  logic [3:0] prescale;                              // Divide-by-12 phase
  logic div_pulse;                                   // One cycle in twelve
  logic [NUM_TIMERS-1:0] pin_meta;                   // Sync stage one
  logic [NUM_TIMERS-1:0] pin_sync;                   // Sync stage two
  logic [NUM_TIMERS-1:0] pin_prev;                   // Edge history
  logic [NUM_TIMERS-1:0] pin_fall;                   // Falling edge seen
  logic [NUM_TIMERS-1:0] fast_sel;                   // Per-timer select bit
  logic [NUM_TIMERS-1:0] next_tick;                  // Selected tick

  // Address match used by both read and write paths
  function automatic logic reg_hit(input logic [SFR_AW-1:0] addr);
    reg_hit = (addr == TICK_DIV_SEL_ADDR);
  endfunction : reg_hit

  // Tick choice for one timer from its control and the shared pulses
  function automatic logic pick_tick(input ttps_ctrl_s ctrl, input logic baud_ok,
                                     input logic sel, input logic fall, input logic slow);
    if (ctrl.count_source) begin
      pick_tick = fall;                   // Counter function
    end else if (baud_ok && ctrl.baud_mode) begin
      pick_tick = 1'b1;                   // Baud mode, select ignored
    end else begin
      pick_tick = sel ? 1'b1 : slow;      // Timer function
    end
  endfunction : pick_tick

  // ----------------------------------------------------------------------
  // Clock-control register
  // ----------------------------------------------------------------------
  // Only the select bits are stored; unused and reserved bits hold nothing
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tick_sel <= TICK_DIV_SEL_RESET[TICK_FIELD_MSB:TICK_FIELD_LSB];
    end else if (sfr_wr_i && reg_hit(sfr_addr_i)) begin
      tick_sel <= sfr_wdata_i[TICK_FIELD_MSB:TICK_FIELD_LSB];
    end
  end

  // A write to the register address lands in the select field
  sel_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (sfr_wr_i && reg_hit(sfr_addr_i)) |=> tick_sel == $past(sfr_wdata_i[TICK_FIELD_MSB:TICK_FIELD_LSB]))
    else $error("select write lost");

  // Without a write the select field keeps its value
  sel_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !(sfr_wr_i && reg_hit(sfr_addr_i)) |=> $stable(tick_sel))
    else $error("select changed without write");

  // Registered read; unused and reserved bits read zero
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sfr_rdata_o <= TICK_DIV_SEL_RESET;
    end else if (sfr_rd_i && reg_hit(sfr_addr_i)) begin
      sfr_rdata_o <= {1'b0, tick_sel, 3'h0};
    end else begin
      sfr_rdata_o <= '0;                  // No data off this address
    end
  end

  // Reads off the register address, or with no strobe, return zero
  rdata_idle_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !(sfr_rd_i && reg_hit(sfr_addr_i)) |=> sfr_rdata_o == '0)
    else $error("read data off address");

  // Unused and reserved bits always read zero
  rdata_resv_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sfr_rdata_o[SFR_DW-1] == 1'b0 && sfr_rdata_o[TICK_FIELD_LSB-1:0] == '0)
    else $error("reserved bits read nonzero");

  // Map stored bits onto timers; timer 3 has none and in timer function stays on the slow tick
  assign fast_sel = {tick_sel[TIMER_FOUR_TICK_BIT], 1'b0, tick_sel[TIMER_TWO_TICK_BIT],
                     tick_sel[TIMER_ONE_TICK_BIT], tick_sel[TIMER_ZERO_TICK_BIT]} & HAS_TICK_SEL;

  // ----------------------------------------------------------------------
  // Divide-by-twelve prescaler
  // ----------------------------------------------------------------------
  // Free-running phase shared by all timers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      prescale <= PRESCALE_ZERO;
    end else if (prescale == PRESCALE_LAST) begin
      prescale <= PRESCALE_ZERO;
    end else begin
      prescale <= prescale + 4'h1;
    end
  end

  assign div_pulse = (prescale == PRESCALE_LAST);

  // ----------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------------
  // Two flops against metastability, a third to remember the last level
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pin_meta <= '1;
      pin_sync <= '1;
      pin_prev <= '1;
    end else begin
      pin_meta <= event_pin_i;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // One cycle per high-to-low transition; each level lasts two clocks or more
  assign pin_fall = pin_prev & ~pin_sync;

  // ----------------------------------------------------------------------
  // Per-timer tick selection and count registers
  // ----------------------------------------------------------------------
  for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_timer
    // Each timer picks its own source
    assign next_tick[t] = pick_tick(timer_ctrl_i[t], BAUD_CAPABLE[t], fast_sel[t],
                                    pin_fall[t], div_pulse);

    // Registered tick pulse
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        tick_o[t] <= 1'b0;
      end else begin
        tick_o[t] <= next_tick[t];
      end
    end

    // Count advances by one on each delivered tick while running
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        count_o[t] <= '0;
      end else if (tick_o[t] && timer_ctrl_i[t].run) begin
        count_o[t] <= count_o[t] + COUNT_W'(1);
      end
    end

    // Checks for this timer
    count_step_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (tick_o[t] && timer_ctrl_i[t].run) |=> count_o[t] == $past(count_o[t]) + COUNT_W'(1))
      else $error("count did not step on tick");

    count_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !(tick_o[t] && timer_ctrl_i[t].run) |=> $stable(count_o[t]))
      else $error("count moved without tick");

    edge_count_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (timer_ctrl_i[t].count_source && $fell(pin_sync[t])) |=> tick_o[t])
      else $error("pin falling edge not ticked");

    // Counter function gives no tick without a pin falling edge
    edge_only_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (timer_ctrl_i[t].count_source && !$fell(pin_sync[t])) |=> !tick_o[t])
      else $error("tick without pin edge");

    // Falls four clocks apart, the fastest legal rate, each give one tick
    quarter_rate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (timer_ctrl_i[t].count_source && $fell(pin_sync[t])) ##2 $rose(pin_sync[t]) ##2
      (timer_ctrl_i[t].count_source && $fell(pin_sync[t])) |=> tick_o[t] ##1 !tick_o[t])
      else $error("edge lost at quarter rate");

    pin_ignored_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (!timer_ctrl_i[t].count_source && !timer_ctrl_i[t].baud_mode && !fast_sel[t] && !div_pulse)
      |=> !tick_o[t])
      else $error("timer ticked off schedule");

    if (BAUD_CAPABLE[t]) begin : g_baud
      baud_ignore_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (!timer_ctrl_i[t].count_source && timer_ctrl_i[t].baud_mode) |=> tick_o[t])
        else $error("baud mode did not ignore select");
    end

    fast_tick_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (fast_sel[t] && !timer_ctrl_i[t].count_source) |=> tick_o[t])
      else $error("fast tick missing");

    // Timer function on the slow tick follows the prescaler pulse
    slow_tick_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (!timer_ctrl_i[t].count_source && !(BAUD_CAPABLE[t] && timer_ctrl_i[t].baud_mode) && !fast_sel[t]
       && div_pulse) |=> tick_o[t])
      else $error("slow tick missing");
  end

  // ----------------------------------------------------------------------
  // Prescaler checks
  // ----------------------------------------------------------------------
  div_period_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    div_pulse |-> ##12 div_pulse)
    else $error("prescaler period not twelve");

  div_quiet_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    div_pulse |=> (!div_pulse) [*8])
    else $error("prescaler pulsed early");

endmodule : ttps_timer_tick_prescale_select
